// ==== verilog/lfa_pkg.sv ====
// Package for the literal and file add/AND execution slice.
// Assumes one 20 MHz core clock; decode and file memory share that clock.
// Functional notes
// - Add-literal adds W and an 8-bit literal (0 to 255), writes W, updates C, digit carry, Z.
// - AND-literal (11 1001 kkkk kkkk) ANDs W with the literal, writes W, changes only Z.
// - Add-file (00 0111 dfff ffff) adds W and file f, updates C, digit carry, Z; d picks W or f.
// - AND-file (00 0101 dfff ffff) ANDs W with file f, updates only Z; d=0 to W, d=1 to f.
package lfa_pkg;

   // Widths
   localparam int INSTR_W = 14;
   localparam int DATA_W  = 8;
   localparam int FADDR_W = 7;
   localparam int BIT_W   = 3;
   localparam int FLAG_W  = 3;
   localparam int RADDR_W = 8;

   // Opcode match patterns and field positions
   localparam logic [4:0] ADD_LIT_PAT   = 5'h1F;  // Bits 13:9 = 11 111x
   localparam logic [5:0] AND_LIT_PAT   = 6'h39;  // Bits 13:8 = 11 1001
   localparam logic [5:0] ADD_FILE_PAT  = 6'h07;  // Bits 13:8 = 00 0111
   localparam logic [5:0] AND_FILE_PAT  = 6'h05;  // Bits 13:8 = 00 0101
   localparam logic [3:0] CLR_BIT_PAT   = 4'h4;   // Bits 13:10 = 01 00
   localparam int         DEST_POS      = 7;
   localparam int         BIT_LSB       = 7;

   // Flag positions in the status register
   localparam int CARRY_POS = 0;
   localparam int DIGIT_POS = 1;
   localparam int ZERO_POS  = 2;

   // Reset values
   localparam logic [DATA_W-1:0] WORK_RST  = 8'h00;
   localparam logic [FLAG_W-1:0] FLAGS_RST = 3'h0;
   localparam logic [DATA_W-1:0] COUNT_RST = 8'h00;

   // Register offsets on the software port
   localparam logic [RADDR_W-1:0] WORK_REG_ADDR   = 8'h00;
   localparam logic [RADDR_W-1:0] STATUS_REG_ADDR = 8'h04;
   localparam logic [RADDR_W-1:0] COUNT_REG_ADDR  = 8'h08;

   // Decoded operation
   typedef enum logic [2:0] {
      LFA_OP_NONE,
      LFA_OP_ADD_LITERAL_TO_WORK,
      LFA_OP_AND_LITERAL_WITH_WORK,
      LFA_OP_ADD_WORK_AND_FILE,
      LFA_OP_AND_WORK_WITH_FILE,
      LFA_OP_CLEAR_FILE_BIT
   } lfa_op_e;

endpackage

// ==== verilog/lfa_op_if.sv ====
// Interface carrying a decoded operation and the ALU answer inside the slice.
// Assumes decoder, ALU and core sit on one clock; all signals are combinational.
interface lfa_op_if;
   lfa_pkg::lfa_op_e                  op;
   logic [lfa_pkg::DATA_W-1:0]        operand;      // Literal or file value
   logic [lfa_pkg::FADDR_W-1:0]       file_addr;
   logic                              dest_file;
   logic [lfa_pkg::BIT_W-1:0]         bit_idx;
   logic [lfa_pkg::DATA_W-1:0]        result;
   logic                              carry;
   logic                              digit_carry_flag;
   logic                              zero;

   modport decoder (output op, operand, file_addr, dest_file, bit_idx);
   modport alu     (input op, operand, bit_idx,
                    output result, carry, digit_carry_flag, zero);
   modport core    (input op, file_addr, dest_file, result, carry, digit_carry_flag, zero);
endinterface

// ==== verilog/lfa_decode.sv ====
// Instruction decoder for the five supported operations.
// Assumes instruction word and file read data arrive together on one clock.
module lfa_decode (
   input  wire logic                         instr_valid_in,
   input  wire logic [lfa_pkg::INSTR_W-1:0]  instr_in,
   input  wire logic [lfa_pkg::DATA_W-1:0]   file_data_in,
   lfa_op_if.decoder                         op_bus
);

   // Pattern match on the high opcode bits, fields from the low bits
   always_comb begin
      op_bus.op        = lfa_pkg::LFA_OP_NONE;
      op_bus.operand   = file_data_in;
      op_bus.file_addr = instr_in[lfa_pkg::FADDR_W-1:0];
      op_bus.dest_file = instr_in[lfa_pkg::DEST_POS];
      op_bus.bit_idx   = instr_in[lfa_pkg::BIT_LSB +: lfa_pkg::BIT_W];
      if (instr_valid_in) begin
         if (instr_in[13:9] == lfa_pkg::ADD_LIT_PAT) begin
            op_bus.op      = lfa_pkg::LFA_OP_ADD_LITERAL_TO_WORK;
            op_bus.operand = instr_in[lfa_pkg::DATA_W-1:0];
         end else if (instr_in[13:8] == lfa_pkg::AND_LIT_PAT) begin
            op_bus.op      = lfa_pkg::LFA_OP_AND_LITERAL_WITH_WORK;
            op_bus.operand = instr_in[lfa_pkg::DATA_W-1:0];
         end else if (instr_in[13:8] == lfa_pkg::ADD_FILE_PAT) begin
            op_bus.op = lfa_pkg::LFA_OP_ADD_WORK_AND_FILE;
         end else if (instr_in[13:8] == lfa_pkg::AND_FILE_PAT) begin
            op_bus.op = lfa_pkg::LFA_OP_AND_WORK_WITH_FILE;
         end else if (instr_in[13:10] == lfa_pkg::CLR_BIT_PAT) begin
            op_bus.op = lfa_pkg::LFA_OP_CLEAR_FILE_BIT;
         end
      end
   end

endmodule

// ==== verilog/lfa_alu.sv ====
// Combinational add/AND/bit-clear unit with carry, digit carry and zero.
// Assumes the core decides which flags and destinations are committed.
module lfa_alu (
   input  wire logic [lfa_pkg::DATA_W-1:0]  work_in,
   lfa_op_if.alu                            op_bus
);

   // Nine-bit sum; top bit is the carry out
   function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b);
      return {1'b0, a} + {1'b0, b};
   endfunction

   // Carry out of the low nibble
   function automatic logic nib_carry(input logic [7:0] a, input logic [7:0] b);
      logic [4:0] s;
      s = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      return s[4];
   endfunction

   logic [8:0] sum;

   // Select result by operation
   always_comb begin
      sum                     = add9(work_in, op_bus.operand);
      op_bus.carry            = sum[8];
      op_bus.digit_carry_flag = nib_carry(work_in, op_bus.operand);
      case (op_bus.op)
         lfa_pkg::LFA_OP_ADD_LITERAL_TO_WORK,
         lfa_pkg::LFA_OP_ADD_WORK_AND_FILE:
            op_bus.result = sum[7:0];
         lfa_pkg::LFA_OP_AND_LITERAL_WITH_WORK,
         lfa_pkg::LFA_OP_AND_WORK_WITH_FILE:
            op_bus.result = work_in & op_bus.operand;
         lfa_pkg::LFA_OP_CLEAR_FILE_BIT:
            op_bus.result = op_bus.operand & ~(8'h01 << op_bus.bit_idx);
         default:
            op_bus.result = work_in;
      endcase
      op_bus.zero = (op_bus.result == 8'h00);
   end

endmodule

// ==== verilog/lfa_unit.sv ====
// Top of the execution slice: working register, flags, file write-back, software port.
// Assumes decode presents one instruction per clock with its file data already read,
// and that the file memory takes the registered write one cycle after issue.
module lfa_unit (
   input  wire logic                         clk_in,
   input  wire logic                         arst_n_in,
   input  wire logic                         instr_valid_in,
   input  wire logic [lfa_pkg::INSTR_W-1:0]  instr_in,
   input  wire logic [lfa_pkg::DATA_W-1:0]   file_data_in,
   input  wire logic [lfa_pkg::RADDR_W-1:0]  reg_addr_in,
   input  wire logic [lfa_pkg::DATA_W-1:0]   reg_wdata_in,
   input  wire logic                         reg_wr_in,
   input  wire logic                         reg_rd_in,
   output logic      [lfa_pkg::DATA_W-1:0]   reg_rdata_out,
   output logic                              file_we_out,
   output logic      [lfa_pkg::FADDR_W-1:0]  file_addr_out,
   output logic      [lfa_pkg::DATA_W-1:0]   file_wdata_out,
   output logic      [lfa_pkg::DATA_W-1:0]   work_out,
   output logic      [lfa_pkg::FLAG_W-1:0]   flags_out,
   output logic                              done_out
);

   lfa_op_if op_bus ();

   logic [lfa_pkg::DATA_W-1:0]  work_q,   work_d;
   logic [lfa_pkg::FLAG_W-1:0]  flags_q,  flags_d;
   logic [lfa_pkg::DATA_W-1:0]  count_q,  count_d;
   logic [lfa_pkg::DATA_W-1:0]  rdata_q,  rdata_d;
   logic                        fwe_q,    fwe_d;
   logic [lfa_pkg::FADDR_W-1:0] faddr_q,  faddr_d;
   logic [lfa_pkg::DATA_W-1:0]  fwdata_q, fwdata_d;
   logic                        done_q,   done_d;

   // Decode and arithmetic
   lfa_decode u_decode (
      .instr_valid_in (instr_valid_in),
      .instr_in       (instr_in),
      .file_data_in   (file_data_in),
      .op_bus         (op_bus.decoder)
   );

   lfa_alu u_alu (
      .work_in (work_q),
      .op_bus  (op_bus.alu)
   );

   // Software writes first, then the executing instruction overrides them
   always_comb begin
      work_d   = work_q;
      flags_d  = flags_q;
      count_d  = count_q;
      fwe_d    = 1'b0;
      faddr_d  = faddr_q;
      fwdata_d = fwdata_q;
      done_d   = 1'b0;
      if (reg_wr_in && reg_addr_in == lfa_pkg::WORK_REG_ADDR) begin
         work_d = reg_wdata_in;
      end
      if (reg_wr_in && reg_addr_in == lfa_pkg::STATUS_REG_ADDR) begin
         flags_d = reg_wdata_in[lfa_pkg::FLAG_W-1:0];
      end
      case (op_bus.op)
         lfa_pkg::LFA_OP_ADD_LITERAL_TO_WORK: begin
            work_d                       = op_bus.result;
            flags_d[lfa_pkg::CARRY_POS]  = op_bus.carry;
            flags_d[lfa_pkg::DIGIT_POS]  = op_bus.digit_carry_flag;
            flags_d[lfa_pkg::ZERO_POS]   = op_bus.zero;
         end
         lfa_pkg::LFA_OP_AND_LITERAL_WITH_WORK: begin
            work_d                       = op_bus.result;
            flags_d[lfa_pkg::ZERO_POS]   = op_bus.zero;
         end
         lfa_pkg::LFA_OP_ADD_WORK_AND_FILE: begin
            flags_d[lfa_pkg::CARRY_POS]  = op_bus.carry;
            flags_d[lfa_pkg::DIGIT_POS]  = op_bus.digit_carry_flag;
            flags_d[lfa_pkg::ZERO_POS]   = op_bus.zero;
            if (op_bus.dest_file) begin
               fwe_d = 1'b1;
            end else begin
               work_d = op_bus.result;
            end
         end
         lfa_pkg::LFA_OP_AND_WORK_WITH_FILE: begin
            flags_d[lfa_pkg::ZERO_POS]   = op_bus.zero;
            if (op_bus.dest_file) begin
               fwe_d = 1'b1;
            end else begin
               work_d = op_bus.result;
            end
         end
         lfa_pkg::LFA_OP_CLEAR_FILE_BIT: begin
            fwe_d = 1'b1;
         end
         default: begin
         end
      endcase
      if (op_bus.op != lfa_pkg::LFA_OP_NONE) begin
         faddr_d  = op_bus.file_addr;
         fwdata_d = op_bus.result;
         done_d   = 1'b1;
         count_d  = count_q + 8'h01;
      end
   end

   // Read data stand one cycle after the strobe, zero otherwise
   always_comb begin
      rdata_d = 8'h00;
      if (reg_rd_in) begin
         case (reg_addr_in)
            lfa_pkg::WORK_REG_ADDR:   rdata_d = work_q;
            lfa_pkg::STATUS_REG_ADDR: rdata_d = {5'h00, flags_q};
            lfa_pkg::COUNT_REG_ADDR:  rdata_d = count_q;
            default:                  rdata_d = 8'h00;
         endcase
      end
   end

   // State registers
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         work_q   <= lfa_pkg::WORK_RST;
         flags_q  <= lfa_pkg::FLAGS_RST;
         count_q  <= lfa_pkg::COUNT_RST;
         rdata_q  <= 8'h00;
         fwe_q    <= 1'b0;
         faddr_q  <= 7'h00;
         fwdata_q <= 8'h00;
         done_q   <= 1'b0;
      end else begin
         work_q   <= work_d;
         flags_q  <= flags_d;
         count_q  <= count_d;
         rdata_q  <= rdata_d;
         fwe_q    <= fwe_d;
         faddr_q  <= faddr_d;
         fwdata_q <= fwdata_d;
         done_q   <= done_d;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata_out  = rdata_q;
   assign file_we_out    = fwe_q;
   assign file_addr_out  = faddr_q;
   assign file_wdata_out = fwdata_q;
   assign work_out       = work_q;
   assign flags_out      = flags_q;
   assign done_out       = done_q;

endmodule

// ==== verification/lfa_unit_properties.sv ====
// Checker of the add/AND/bit-clear slice, bound to lfa_unit.
// Assumes the port widths of lfa_unit and no register write beside an instruction.
module lfa_unit_properties (
   input wire logic        clk_in, arst_n_in, instr_valid_in, reg_wr_in, reg_rd_in,
   input wire logic        file_we_out, done_out,
   input wire logic [13:0] instr_in,
   input wire logic [7:0]  file_data_in, reg_addr_in, reg_wdata_in, reg_rdata_out,
   input wire logic [7:0]  file_wdata_out, work_out,
   input wire logic [6:0]  file_addr_out,
   input wire logic [2:0]  flags_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       go, ad_l, an_l, ad_f, an_f, clr, zs, za;
   logic [7:0] opnd, andv, clrv;
   logic [8:0] sum_c;
   logic [4:0] nib_c;
   // Reference decode and results
   assign go    = instr_valid_in && !reg_wr_in;
   assign ad_l  = go && instr_in[13:9] == lfa_pkg::ADD_LIT_PAT;
   assign an_l  = go && instr_in[13:8] == lfa_pkg::AND_LIT_PAT;
   assign ad_f  = go && instr_in[13:8] == lfa_pkg::ADD_FILE_PAT;
   assign an_f  = go && instr_in[13:8] == lfa_pkg::AND_FILE_PAT;
   assign clr   = go && instr_in[13:10] == lfa_pkg::CLR_BIT_PAT;
   assign opnd  = instr_in[13] ? instr_in[7:0] : file_data_in;
   assign sum_c = {1'b0, work_out} + {1'b0, opnd};
   assign nib_c = {1'b0, work_out[3:0]} + {1'b0, opnd[3:0]};
   assign zs    = sum_c[7:0] == 8'h00;
   assign andv  = work_out & opnd;
   assign za    = andv == 8'h00;
   assign clrv  = file_data_in & ~(8'h01 << instr_in[9:7]);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   add_lit_a: assert property (ad_l |=> work_out == $past(sum_c[7:0])
      && flags_out == {$past(zs), $past(nib_c[4]), $past(sum_c[8])})
      else $error("add literal result or flags wrong");
   and_lit_a: assert property (an_l |=> work_out == $past(andv)
      && $stable(flags_out[1:0]) && flags_out[2] == $past(za))
      else $error("and literal result or flags wrong");
   add_file_a: assert property (ad_f |=>
      flags_out == {$past(zs), $past(nib_c[4]), $past(sum_c[8])}
      && ($past(instr_in[7]) ? file_we_out && file_wdata_out == $past(sum_c[7:0])
      && file_addr_out == $past(instr_in[6:0]) && $stable(work_out)
      : !file_we_out && work_out == $past(sum_c[7:0])))
      else $error("add file result, destination or flags wrong");
   and_file_a: assert property (an_f |=> $stable(flags_out[1:0])
      && flags_out[2] == $past(za) && ($past(instr_in[7]) ?
      file_we_out && file_wdata_out == $past(andv) : work_out == $past(andv)))
      else $error("and file result, destination or flags wrong");
   clear_bit_a: assert property (clr |=> done_out && file_we_out
      && file_wdata_out == $past(clrv) && $stable(flags_out) && $stable(work_out))
      else $error("bit clear result wrong or state disturbed");
   idle_quiet_a: assert property (!instr_valid_in |=> !done_out && !file_we_out)
      else $error("activity without an instruction");
   // Main scenarios reached
   cover property (ad_f && instr_in[7]);
   cover property (an_f && instr_in[7]);
   cover property (clr ##1 clr);
endmodule
bind lfa_unit lfa_unit_properties u_props (.*);

// ==== verification/lfa_file_model.sv ====
// File register memory feeding the slice its operand.
// Assumes a write lands on the edge that ends the slice's write pulse.
module lfa_file_model (
   input  wire logic       clk_in, valid_in, we_in,
   input  wire logic [6:0] addr_in, waddr_in,
   input  wire logic [7:0] wdata_in,
   output logic      [7:0] rdata_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [128];
   // Start pattern: three times the address
   initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 3);
   // Store the write-back
   always @(posedge clk_in) begin
      if (we_in) mem[waddr_in] <= wdata_in;
   end
   // Forward a write in flight; junk when nothing reads
   always_comb begin
      if (!valid_in) rdata_out = ~mem[addr_in];
      else if (we_in && waddr_in == addr_in) rdata_out = wdata_in;
      else rdata_out = mem[addr_in];
   end
endmodule

// ==== verification/lfa_unit_tb_top.sv ====
// Self-checking bench for lfa_unit: instruction runs and register port.
// Assumes the file model forwards a write still in flight.
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
   $display("wrong value %s exp %0h got %0h", n, e, g); end end
module lfa_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_in = 1'b0, arst_n_in = 1'b0, instr_valid_in = 1'b0;
   logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, file_we_out, done_out;
   logic [13:0] instr_in = 14'h0000;
   logic [7:0]  reg_addr_in = 8'h00, reg_wdata_in = 8'h00, file_data_in, v;
   logic [7:0]  reg_rdata_out, file_wdata_out, work_out;
   logic [6:0]  file_addr_out;
   logic [2:0]  flags_out;
   int          n_mismatch = 0, check_count = 0, cyc = 0;
   // 20 MHz clock
   always #25 clk_in = ~clk_in;
   lfa_unit dut (.*);
   lfa_file_model u_file (.clk_in, .valid_in(instr_valid_in), .we_in(file_we_out),
      .addr_in(instr_in[6:0]), .waddr_in(file_addr_out), .wdata_in(file_wdata_out),
      .rdata_out(file_data_in));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Issue one instruction; outputs settled on return
   task automatic ex(input logic [13:0] i);
      instr_valid_in <= 1'b1;
      instr_in       <= i;
      @(posedge clk_in);
      #1;
   endtask
   task automatic exw(input logic [13:0] i, input logic [7:0] w, input logic [2:0] f);
      ex(i);
      `CHK("work", w, work_out)
      `CHK("flags", f, flags_out)
      `CHK("done", 1'b1, done_out)
   endtask
   task automatic chf(input logic we, input logic [7:0] d);
      `CHK("file we", we, file_we_out)
      `CHK("file data", d, file_wdata_out)
   endtask
   // Register write, then one quiet cycle
   task automatic wr(input logic [7:0] a, d);
      instr_valid_in <= 1'b0;
      reg_wr_in      <= 1'b1;
      reg_addr_in    <= a;
      reg_wdata_in   <= d;
      @(posedge clk_in);
      #1;
      reg_wr_in <= 1'b0;
      @(posedge clk_in);
      #1;
   endtask
   task automatic rd(input logic [7:0] a, e);
      instr_valid_in <= 1'b0;
      reg_rd_in      <= 1'b1;
      reg_addr_in    <= a;
      @(posedge clk_in);
      #1;
      reg_rd_in <= 1'b0;
      `CHK("read", e, reg_rdata_out)
      @(posedge clk_in);
      #1;
      // Read data stand one cycle only, then return to zero
      `CHK("read idle", 8'h00, reg_rdata_out)
   endtask
   // Hang guard
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      repeat (16) @(posedge clk_in);
      arst_n_in <= 1'b1;
      wr(lfa_pkg::WORK_REG_ADDR, 8'h10);
      exw(14'h3E15, 8'h25, 3'h0);
      exw(14'h3EF0, 8'h15, 3'h1);
      exw(14'h3E0B, 8'h20, 3'h2);
      exw(14'h3FE0, 8'h00, 3'h5);
      exw(14'h3FFF, 8'hFF, 3'h0);
      exw(14'h3E01, 8'h00, 3'h7);
      exw(14'h3EA3, 8'hA3, 3'h0);
      wr(lfa_pkg::STATUS_REG_ADDR, 8'h03);
      exw(14'h395F, 8'h03, 3'h3);
      exw(14'h3900, 8'h00, 3'h7);
      ex(14'h3800);
      `CHK("ignored", 1'b0, done_out)
      wr(lfa_pkg::WORK_REG_ADDR, 8'h17);
      rd(lfa_pkg::WORK_REG_ADDR, 8'h17);
      exw(14'h0741, 8'hDA, 3'h0);
      exw(14'h07D5, 8'hDA, 3'h3);
      chf(1'b1, 8'hD9);
      `CHK("file addr", 7'h55, file_addr_out)
      exw(14'h0755, 8'hB3, 3'h3);
      `CHK("file we", 1'b0, file_we_out)
      exw(14'h05D5, 8'hB3, 3'h3);
      chf(1'b1, 8'h91);
      exw(14'h052A, 8'h32, 3'h3);
      exw(14'h0500, 8'h00, 3'h7);
      v = 8'h7D;
      for (int b = 0; b < 8; b++) begin
         v = v & ~(8'h01 << b);
         exw(14'h107F | 14'(b << 7), 8'h00, 3'h7);
         chf(1'b1, v);
      end
      rd(lfa_pkg::WORK_REG_ADDR, 8'h00);
      rd(lfa_pkg::STATUS_REG_ADDR, 8'h07);
      rd(8'h10, 8'h00);
      rd(lfa_pkg::COUNT_REG_ADDR, 8'h17);
      give_verdict();
   end
endmodule
